// file: logic/code_table16.v
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Constant lookup: a four-bit code selects one of sixteen packed entries.
// ----------------------------------------------------------------------------
module code_table16 #(
	parameter W     = 16,
	parameter TABLE = {16*16{1'b0}}
) (
	// Code in.
	input  wire [3:0]   code,
	// Entry out.
	output wire [W-1:0] value
);
	assign value = TABLE[code*W +: W];
endmodule // code_table16

// file: logic/code_table8.v
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Constant lookup: a three-bit code selects one of eight packed entries.
// ----------------------------------------------------------------------------
module code_table8 #(
	parameter W     = 16,
	parameter TABLE = {8*16{1'b0}}
) (
	// Code in.
	input  wire [2:0]   code,
	// Entry out.
	output wire [W-1:0] value
);
	assign value = TABLE[code*W +: W];
endmodule // code_table8

// file: logic/motor_startup_config.v
`timescale 1ns/10ps
`include "startup_defines.vh"

// Overview of operation
// RQ1: 32-bit RW register at 84h, resets zero.
// RQ2: Bits 30-29 pick the startup method.
// RQ3: Bits 28-25 set ramp rate; Fh unlimited.
// RQ4: Bits 24-21 map align time 10ms-10s.
// RQ5: Bits 20-17 map align cap 0.125-8A.
// RQ6: Bits 16-14 pick probe pulse rate.
// RQ7: Bits 13-9 threshold; codes above 11h invalid.
// RQ8: Bit 8 selects brake or tristate release.
// RQ9: Bits 7-6 add 0-90 degree lead.
// RQ10: Bits 5-4 give one to four probe runs.
// RQ11: Bit 3 picks open-loop cap source.
// RQ12: Bit 2 enables torque current ramp-down.
// RQ13: Bit 1 enables active braking.
// RQ14: Bit 0 selects reverse-drive parameter source.
// RQ15: Reverse open-loop cap code gives 1.5-5.0A.
module motor_startup_config (
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        resetn,
	// Register port, same clock domain.
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	output reg         reg_hit,
	// Inputs from neighbouring registers.
	input  wire [3:0]  open_loop_current_cap,
	input  wire [3:0]  general_current_cap,
	input  wire [1:0]  reverse_open_loop_current_cap,
	// Decoded startup method, one-hot.
	output reg         method_align,
	output reg         method_double_align,
	output reg         method_initial_position_probe,
	output reg         method_slow_first_cycle,
	// Align and ramp settings.
	output reg  [15:0] ramp_rate_dacps,
	output reg         ramp_unlimited,
	output reg  [15:0] align_time_ms,
	output reg  [9:0]  align_current_cap_ma8,
	// Position probe settings.
	output reg  [13:0] position_probe_pulse_rate_hz,
	output reg  [13:0] position_probe_current_threshold_ma,
	output reg         position_probe_threshold_valid,
	output reg         position_probe_release_tristate,
	output reg  [6:0]  position_probe_lead_angle_deg,
	output reg  [2:0]  position_probe_runs,
	// Open loop and drive options.
	output reg  [3:0]  open_loop_cap_code,
	output reg         torque_current_rampdown_on,
	output reg         active_brake_on,
	output reg         reverse_param_select,
	output reg  [12:0] reverse_open_loop_cap_ma
);
	// ------------------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------------------
	reg  [31:0] startup_config_one_reg;
	wire        sel = (reg_addr == `STARTUP_CONFIG_ONE_OFFSET);

	// Every bit, bit 31 included, is plain read/write storage.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			startup_config_one_reg <= `STARTUP_CONFIG_ONE_RESET; // RQ1
		end else if (reg_wr && sel) begin
			startup_config_one_reg <= reg_wdata; // RQ1
		end
	end

	// Hit answers one cycle after the strobe and stands for as many cycles as the strobe did.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_hit <= 1'b0;
		end else begin
			reg_hit <= (reg_wr | reg_rd) & sel;
		end
	end

	// A write in the same cycle as a read returns the old contents.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= (reg_rd && sel) ? startup_config_one_reg : 32'h00000000; // RQ1
		end
	end

	// ------------------------------------------------------------------------
	// Field extraction.
	// ------------------------------------------------------------------------
	wire [1:0] f_method = startup_config_one_reg[`F_METHOD_HI:`F_METHOD_LO];
	wire [3:0] f_ramp   = startup_config_one_reg[`F_RAMP_HI:`F_RAMP_LO];
	wire [3:0] f_time   = startup_config_one_reg[`F_ALIGN_T_HI:`F_ALIGN_T_LO];
	wire [3:0] f_cap    = startup_config_one_reg[`F_ALIGN_CAP_HI:`F_ALIGN_CAP_LO];
	wire [2:0] f_rate   = startup_config_one_reg[`F_PROBE_RATE_HI:`F_PROBE_RATE_LO];
	wire [4:0] f_thr    = startup_config_one_reg[`F_PROBE_THR_HI:`F_PROBE_THR_LO];
	wire [1:0] f_lead   = startup_config_one_reg[`F_LEAD_HI:`F_LEAD_LO];
	wire [1:0] f_rep    = startup_config_one_reg[`F_REPEAT_HI:`F_REPEAT_LO];

	// ------------------------------------------------------------------------
	// Code tables.
	// ------------------------------------------------------------------------
	// Ramp rate in tenths of A/s; entry F is a don't-care, the flag carries it.
	wire [15:0] ramp_val;
	code_table16 #(
		.W     (16),
		.TABLE ({
			16'h0000,
			16'hC350,
			16'h4E20,
			16'h2710,
			16'h1388,
			16'h09C4,
			16'h07D0,
			16'h05DC,
			16'h03E8,
			16'h01F4,
			16'h00FA,
			16'h0096,
			16'h0064,
			16'h0032,
			16'h000A,
			16'h0001
		})
	) u_ramp (
		.code  (f_ramp),
		.value (ramp_val)
	); // RQ3

	wire [15:0] time_val;
	code_table16 #(
		.W     (16),
		.TABLE ({
			16'h2710,
			16'h1D4C,
			16'h1388,
			16'h0FA0,
			16'h0BB8,
			16'h07D0,
			16'h05DC,
			16'h03E8,
			16'h02EE,
			16'h01F4,
			16'h0190,
			16'h012C,
			16'h00C8,
			16'h0064,
			16'h0032,
			16'h000A
		})
	) u_time (
		.code  (f_time),
		.value (time_val)
	); // RQ4

	// Current cap in eighths of an ampere keeps every step an integer.
	wire [9:0] cap_val;
	code_table16 #(
		.W     (10),
		.TABLE ({
			10'h040,
			10'h038,
			10'h030,
			10'h02C,
			10'h028,
			10'h024,
			10'h020,
			10'h01C,
			10'h018,
			10'h014,
			10'h010,
			10'h00C,
			10'h008,
			10'h004,
			10'h002,
			10'h001
		})
	) u_cap (
		.code  (f_cap),
		.value (cap_val)
	); // RQ5

	wire [13:0] rate_val;
	code_table8 #(
		.W     (14),
		.TABLE ({
			14'h2710,
			14'h1388,
			14'h07D0,
			14'h03E8,
			14'h01F4,
			14'h00FA,
			14'h0064,
			14'h0032
		})
	) u_rate (
		.code  (f_rate),
		.value (rate_val)
	); // RQ6

	// Threshold in mA; thirds of an ampere are rounded to the nearest mA.
	reg [13:0] thr_val;
	always @* begin
		case (f_thr)
			5'h00:   thr_val = 14'h00FA;
			5'h01:   thr_val = 14'h01F4;
			5'h02:   thr_val = 14'h02EE;
			5'h03:   thr_val = 14'h03E8;
			5'h04:   thr_val = 14'h04E2;
			5'h05:   thr_val = 14'h05DC;
			5'h06:   thr_val = 14'h07D0;
			5'h07:   thr_val = 14'h09C4;
			5'h08:   thr_val = 14'h0BB8;
			5'h09:   thr_val = 14'h0E53;
			5'h0A:   thr_val = 14'h0FA0;
			5'h0B:   thr_val = 14'h123B;
			5'h0C:   thr_val = 14'h1388;
			5'h0D:   thr_val = 14'h14D5;
			5'h0E:   thr_val = 14'h1770;
			5'h0F:   thr_val = 14'h1A0B;
			5'h10:   thr_val = 14'h1CA5;
			5'h11:   thr_val = 14'h1F40;
			default: thr_val = 14'h0000;
		endcase
	end // RQ7

	reg [12:0] rev_val;
	always @* begin
		case (reverse_open_loop_current_cap)
			2'h0:    rev_val = 13'h05DC;
			2'h1:    rev_val = 13'h09C4;
			2'h2:    rev_val = 13'h0DAC;
			default: rev_val = 13'h1388;
		endcase
	end // RQ15

	// ------------------------------------------------------------------------
	// Registered outputs.
	// ------------------------------------------------------------------------
	// Outputs lag the register by one cycle so every port leaves a flip-flop.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			method_align                  <= 1'b1;
			method_double_align           <= 1'b0;
			method_initial_position_probe <= 1'b0;
			method_slow_first_cycle       <= 1'b0;
			ramp_rate_dacps               <= `RST_RAMP_RATE;
			ramp_unlimited                <= 1'b0;
			align_time_ms                 <= `RST_ALIGN_TIME;
			align_current_cap_ma8         <= `RST_ALIGN_CAP;
		end else begin
			method_align                  <= (f_method == `METHOD_ALIGN); // RQ2
			method_double_align           <= (f_method == `METHOD_DOUBLE); // RQ2
			method_initial_position_probe <= (f_method == `METHOD_PROBE); // RQ2
			method_slow_first_cycle       <= (f_method == `METHOD_SLOW); // RQ2
			ramp_rate_dacps               <= ramp_val; // RQ3
			ramp_unlimited                <= (f_ramp == `RAMP_NO_LIMIT); // RQ3
			align_time_ms                 <= time_val; // RQ4
			align_current_cap_ma8         <= cap_val; // RQ5
		end
	end

	// Position probe settings.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			position_probe_pulse_rate_hz        <= `RST_PROBE_RATE;
			position_probe_current_threshold_ma <= `RST_PROBE_THR;
			position_probe_threshold_valid      <= 1'b1;
			position_probe_release_tristate     <= 1'b0;
			position_probe_lead_angle_deg       <= 7'h00;
			position_probe_runs                 <= `RST_RUNS;
		end else begin
			position_probe_pulse_rate_hz        <= rate_val; // RQ6
			position_probe_current_threshold_ma <= thr_val; // RQ7
			position_probe_threshold_valid      <= (f_thr <= `THR_LAST_VALID); // RQ7
			position_probe_release_tristate     <= startup_config_one_reg[`F_RELEASE]; // RQ8
			position_probe_lead_angle_deg       <= {5'h00, f_lead} * `LEAD_STEP_DEG; // RQ9
			position_probe_runs                 <= {1'b0, f_rep} + 3'h1; // RQ10
		end
	end

	// Open loop and drive options.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			open_loop_cap_code         <= 4'h0;
			torque_current_rampdown_on <= 1'b0;
			active_brake_on            <= 1'b0;
			reverse_param_select       <= 1'b0;
			reverse_open_loop_cap_ma   <= `RST_REV_CAP;
		end else begin
			// Set selects the general cap, clear the dedicated open-loop cap.
			open_loop_cap_code <= startup_config_one_reg[`F_OL_SRC] ?
				general_current_cap : open_loop_current_cap; // RQ11
			torque_current_rampdown_on <= startup_config_one_reg[`F_RAMPDOWN]; // RQ12
			active_brake_on            <= startup_config_one_reg[`F_BRAKE]; // RQ13
			reverse_param_select       <= startup_config_one_reg[`F_REV_SEL]; // RQ14
			reverse_open_loop_cap_ma   <= rev_val; // RQ15
		end
	end
endmodule // motor_startup_config

// file: logic/startup_defines.vh
`ifndef STARTUP_DEFINES_VH
`define STARTUP_DEFINES_VH
// ----------------------------------------------------------------------------
// Register map and field layout.
// ----------------------------------------------------------------------------
`define STARTUP_CONFIG_ONE_OFFSET 8'h84
`define STARTUP_CONFIG_ONE_RESET  32'h00000000
`define F_METHOD_HI      30
`define F_METHOD_LO      29
`define F_RAMP_HI        28
`define F_RAMP_LO        25
`define F_ALIGN_T_HI     24
`define F_ALIGN_T_LO     21
`define F_ALIGN_CAP_HI   20
`define F_ALIGN_CAP_LO   17
`define F_PROBE_RATE_HI  16
`define F_PROBE_RATE_LO  14
`define F_PROBE_THR_HI   13
`define F_PROBE_THR_LO   9
`define F_RELEASE        8
`define F_LEAD_HI        7
`define F_LEAD_LO        6
`define F_REPEAT_HI      5
`define F_REPEAT_LO      4
`define F_OL_SRC         3
`define F_RAMPDOWN       2
`define F_BRAKE          1
`define F_REV_SEL        0
// ----------------------------------------------------------------------------
// Decoded encodings.
// ----------------------------------------------------------------------------
`define METHOD_ALIGN     2'h0
`define METHOD_DOUBLE    2'h1
`define METHOD_PROBE     2'h2
`define METHOD_SLOW      2'h3
`define RAMP_NO_LIMIT    4'hF
`define THR_LAST_VALID   5'h11
`define LEAD_STEP_DEG    7'h1E
// ----------------------------------------------------------------------------
// Decoded outputs in reset: the decode of an all-zero register.
// ----------------------------------------------------------------------------
`define RST_RAMP_RATE    16'h0001
`define RST_ALIGN_TIME   16'h000A
`define RST_ALIGN_CAP    10'h001
`define RST_PROBE_RATE   14'h0032
`define RST_PROBE_THR    14'h00FA
`define RST_RUNS         3'h1
`define RST_REV_CAP      13'h05DC
`endif

// file: tb/motor_startup_config_properties.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Startup register checker.
// ----------------------------------------------------------------------------
module motor_startup_config_properties (
	// Clock and reset.
	input wire        sys_clk,
	input wire        resetn,
	// Register port.
	input wire [7:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire        reg_hit,
	// Cap sources.
	input wire [3:0]  open_loop_current_cap,
	input wire [3:0]  general_current_cap,
	// Decoded settings.
	input wire        method_align,
	input wire        method_double_align,
	input wire        method_initial_position_probe,
	input wire        method_slow_first_cycle,
	input wire        ramp_unlimited,
	input wire [15:0] align_time_ms,
	input wire        position_probe_threshold_valid,
	input wire [2:0]  position_probe_runs,
	input wire [3:0]  open_loop_cap_code,
	input wire        active_brake_on
);
	wire       req = (reg_wr || reg_rd) && reg_addr == 8'h84;
	reg [31:0] last_w;
	// Shadow of the last accepted write, so decode checks need no deep history.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			last_w <= 32'h00000000;
		else if (reg_wr && reg_addr == 8'h84)
			last_w <= reg_wdata;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_wr; reg_wr && reg_addr == 8'h84 ##1 !reg_wr; endsequence
	property p_hit; req |=> reg_hit; endproperty
	a_hit: assert property (p_hit) else $error("no hit after access");
	property p_miss; !req |=> !reg_hit && reg_rdata == 32'h00000000; endproperty
	a_miss: assert property (p_miss) else $error("stray hit or data");
	property p_back; reg_wr && reg_addr == 8'h84 ##1 !reg_wr ##1 reg_rd && !reg_wr
		&& reg_addr == 8'h84 |=> reg_rdata == last_w; endproperty
	a_back: assert property (p_back) else $error("readback differs");
	property p_meth; s_wr |=> {method_slow_first_cycle, method_initial_position_probe,
		method_double_align, method_align} == 4'h1 << last_w[30:29]; endproperty
	a_meth: assert property (p_meth) else $error("method decode wrong");
	property p_unl; s_wr |=> ramp_unlimited == (last_w[28:25] == 4'hF); endproperty
	a_unl: assert property (p_unl) else $error("unlimited flag wrong");
	property p_time; s_wr |=> (align_time_ms == 16'h000A) == (last_w[24:21] == 4'h0)
		&& (align_time_ms == 16'h2710) == (last_w[24:21] == 4'hF); endproperty
	a_time: assert property (p_time) else $error("align time wrong");
	property p_thr; s_wr |=> position_probe_threshold_valid == (last_w[13:9] <= 5'h11); endproperty
	a_thr: assert property (p_thr) else $error("threshold valid wrong");
	property p_runs; s_wr |=> position_probe_runs == last_w[5:4] + 3'h1; endproperty
	a_runs: assert property (p_runs) else $error("run count wrong");
	property p_src; s_wr |=> open_loop_cap_code == (last_w[3] ? $past(general_current_cap)
		: $past(open_loop_current_cap)); endproperty
	a_src: assert property (p_src) else $error("cap source wrong");
	property p_brk; s_wr |=> active_brake_on == last_w[1]; endproperty
	a_brk: assert property (p_brk) else $error("brake enable wrong");
	c_wr: cover property (s_wr);
	c_both: cover property (reg_rd && reg_wr && reg_addr == 8'h84);
	c_miss: cover property (reg_wr && reg_addr != 8'h84);
endmodule // motor_startup_config_properties

bind motor_startup_config motor_startup_config_properties u_props (.*);

// file: tb/tb_motor_startup_config.sv
`timescale 1ns/10ps
module tb_motor_startup_config;
	// ------------------------------------------------------------------------
	// Stimulus and outputs.
	// ------------------------------------------------------------------------
	logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [3:0] open_loop_current_cap = 4'h0, general_current_cap = 4'h0;
	logic [1:0] reverse_open_loop_current_cap = 2'h0;
	wire [31:0] reg_rdata;
	wire reg_hit, method_align, method_double_align, method_initial_position_probe;
	wire method_slow_first_cycle, ramp_unlimited, position_probe_threshold_valid;
	wire position_probe_release_tristate, torque_current_rampdown_on, active_brake_on;
	wire reverse_param_select;
	wire [15:0] ramp_rate_dacps, align_time_ms;
	wire [9:0] align_current_cap_ma8;
	wire [13:0] position_probe_pulse_rate_hz, position_probe_current_threshold_ma;
	wire [6:0] position_probe_lead_angle_deg;
	wire [2:0] position_probe_runs;
	wire [3:0] open_loop_cap_code;
	wire [12:0] reverse_open_loop_cap_ma;
	int mismatches = 0, check_count = 0;
	logic [31:0] q[$];
	logic [31:0] v;
	int ramp_t[16] = '{1, 10, 50, 100, 150, 250, 500, 1000, 1500, 2000, 2500, 5000, 10000,
		20000, 50000, 0};
	int time_t[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 1500, 2000, 3000, 4000,
		5000, 7500, 10000};
	int cap_t[16] = '{1, 2, 4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 44, 48, 56, 64};
	int rate_t[8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
	int thr_t[18] = '{250, 500, 750, 1000, 1250, 1500, 2000, 2500, 3000, 3667, 4000, 4667,
		5000, 5333, 6000, 6667, 7333, 8000};
	int rev_t[4] = '{1500, 2500, 3500, 5000};

	motor_startup_config dut (.*);

	always #2 sys_clk = ~sys_clk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task summarize;
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One access per call; the strobe drops on the edge that takes it.
	task automatic acc(input logic w, r, input logic [7:0] a, input logic [31:0] d, e);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		if (a == 8'h84)
			q.push_back(r ? e : 32'h00000000);
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask

	task automatic dec(input logic [31:0] x);
		logic [4:0] t;
		t = x[13:9];
		chk("method", 4'h1 << x[30:29], {method_slow_first_cycle,
			method_initial_position_probe, method_double_align, method_align});
		chk("ramp", ramp_t[x[28:25]], ramp_rate_dacps);
		chk("unlimited", x[28:25] == 4'hF, ramp_unlimited);
		chk("time", time_t[x[24:21]], align_time_ms);
		chk("cap", cap_t[x[20:17]], align_current_cap_ma8);
		chk("rate", rate_t[x[16:14]], position_probe_pulse_rate_hz);
		chk("thr", t < 18 ? thr_t[t] : 0, position_probe_current_threshold_ma);
		chk("valid", t < 18, position_probe_threshold_valid);
		chk("lead", x[7:6] * 30, position_probe_lead_angle_deg);
		chk("runs", x[5:4] + 1, position_probe_runs);
		chk("olcap", x[3] ? general_current_cap : open_loop_current_cap,
			open_loop_cap_code);
		chk("bits", {x[8], x[2:0]}, {position_probe_release_tristate,
			torque_current_rampdown_on, active_brake_on, reverse_param_select});
		chk("rev", rev_t[reverse_open_loop_current_cap], reverse_open_loop_cap_ma);
	endtask

	// Every hit must have a note waiting; an empty queue expects unknown and so fails.
	always @(negedge sys_clk) begin
		if (reg_hit === 1'b1)
			chk("reg_rdata", q.size() ? q.pop_front() : 32'hXXXXXXXX, reg_rdata);
	end

	initial begin
		#20000;
		mismatches++;
		summarize;
	end

	initial begin
		void'($urandom(32'hA4FF));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		acc(0, 1, 8'h84, 32'h00000000, 32'h00000000);
		@(negedge sys_clk);
		dec(32'h00000000);
		for (int i = 0; i < 16; i++) begin
			v = $urandom;
			v[30:29] = i[1:0];
			v[28:17] = {3{i[3:0]}};
			v[16:14] = i[2:0];
			v[13:9] = {i[0], i[3:0]};
			v[7:4] = i[3:0];
			@(posedge sys_clk);
			open_loop_current_cap <= 4'($urandom);
			general_current_cap <= 4'($urandom);
			reverse_open_loop_current_cap <= 2'($urandom);
			acc(1, 0, 8'h84, v, 32'h00000000);
			@(posedge sys_clk);
			@(negedge sys_clk);
			dec(v);
			acc(1, 0, i[0] ? 8'h80 : 8'h85, ~v, 32'h00000000);
			acc(0, 1, 8'h85, 32'h00000000, 32'h00000000);
			acc(1, 1, 8'h84, ~v, v);
			acc(0, 1, 8'h84, 32'h00000000, ~v);
		end
		// A reset in mid-run must bring back the all-zero word and its decode.
		open_loop_current_cap <= 4'h0;
		general_current_cap <= 4'h0;
		reverse_open_loop_current_cap <= 2'h0;
		@(posedge sys_clk);
		resetn <= 1'b0;
		@(negedge sys_clk);
		dec(32'h00000000);
		@(posedge sys_clk);
		resetn <= 1'b1;
		acc(0, 1, 8'h84, 32'h00000000, 32'h00000000);
		repeat (3) @(posedge sys_clk);
		chk("pending", 32'h00000000, q.size());
		summarize;
	end
endmodule // tb_motor_startup_config
